// *** shared/xbus_params.svh ***
// expansion bus interface constants: divisor codes, state counts, bit spots
// assumes inclusion from the package and the design file only
`ifndef XBUS_PARAMS_SVH
`define XBUS_PARAMS_SVH
`define XB_DIV_W          4
`define XB_DIV_CODE0      4'h2
`define XB_DIV_CODE1      4'h3
`define XB_DIV_CODE2      4'h4
`define XB_DIV_CODE3      4'h5
`define XB_CNT_ONE        4'h1
`define XB_CNT_ZERO       4'h0
`define XB_WAIT_W         3
`define XB_WAIT_8BIT      3'h4
`define XB_WAIT_16BIT     3'h1
`define XB_WAIT_ZERO      3'h0
`define XB_WAIT_ONE       3'h1
`define XB_ADDR_W         24
`define XB_MEG_BIT        20
`define XB_ADDR_TOP       23
`define XB_ROM_BASE       24'h0e0000
`define XB_ROM_MASK       24'hfe0000
`define XB_REFRESH_NS     15900
`define XB_REFRESH_SLOW_NS 63600
`endif

// *** shared/xbus_pkg.sv ***
// expansion bus interface types: cycle kinds, state codes, request bundle
// assumes xbus_params.svh is on the include path
`include "xbus_params.svh"
package xbus_pkg;
  typedef enum logic [2:0] {
    cyc_mem_rd = 3'h0,
    cyc_mem_wr = 3'h1,
    cyc_io_rd  = 3'h2,
    cyc_io_wr  = 3'h3,
    cyc_int_ack_n   = 3'h4
  } cyc_kind_e;

  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_addr  = 4'h2,
    st_cmd   = 4'h4,
    st_end   = 4'h8
  } xbus_state_e;

  // one cpu request to the expansion bus
  typedef struct packed {
    cyc_kind_e                  kind;
    logic [`XB_ADDR_TOP:0]      addr;
    logic                       bhe;   // upper byte used
  } cpu_req_s;

  // state of bidirectional pins as the bus shows them
  typedef struct packed {
    logic addr0;
    logic gated_addr_bit20;
    logic bhe_n;
    logic m16_n;
    logic refresh_n;
    logic [3:0] cmd_n;  // io_read_strobe_n, io_write_strobe_n, mrd, mwr
  } pin_in_s;
endpackage : xbus_pkg

// *** rtl/expansion_bus_interface.sv ***
// expansion bus interface of the system controller: cpu cycles out to
// 16-bit style bus, pin turnaround for dma and bus masters, refresh, nmi.
// assumes i_clk is the master 2x clock and inputs are synchronous to it;
// arbitration decides i_dma_cycle / i_master_cycle ahead of the cycle.
// Function
// - drive address bit 0 except master or 8-bit dma cycles, then sample
// - channel ready low stretches the memory or io cycle with wait states
// - zero wait request ends the bus cycle with no further waits
// - wide io slave during io cycle makes a single 16-bit access
// - wide memory slave sampled, driven when master accesses local memory
// - drive gated address bit 20, release during master cycles
// - drive command strobes, float and sample them in master and dma cycles
// - assert low megabyte select for memory addresses below one megabyte
// - pulse address latch at cpu cycle start, high in non-cpu cycles
// - byte high enable for upper byte, released in master cycles
// - drive interrupt acknowledge during cpu acknowledge cycles
// - rom width 8 or 16 bits chosen by wide memory slave input
// - cpu rom enable from middle of first t2 to half state after last t2
// - non-cpu rom select follows the memory read command while the master memory read input is high
// - buffer direction high toward expansion bus, low back per lane
// - enable data buffer during cpu accesses to the expansion bus
// - channel check is an uncorrectable error and an nmi source
// - drive refresh output in own refresh, input in dma or master
// - channel check raises nmi only with its control enable set
// - bus clock from 2x clock, one of four divisors by 2-bit field
`timescale 1ns/100ps
`include "xbus_params.svh"
module expansion_bus_interface (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic [1:0]            i_clk_div_sel,
  input  wire logic                  i_cpu_req,
  input  wire xbus_pkg::cpu_req_s    i_cpu,
  output logic                       o_cpu_done,
  input  wire logic                  i_dma_cycle,
  input  wire logic                  i_dma_8bit,
  input  wire logic                  i_master_cycle,
  input  wire logic                  i_master_local_mem,
  input  wire logic                  i_master_mem_rd,
  input  wire logic                  i_refresh_req,
  input  wire logic                  i_channel_ready_in,
  input  wire logic                  i_no_wait_req_n,
  input  wire logic                  i_io_wide_slave_n,
  input  wire logic                  i_channel_check_n,
  input  wire logic                  i_chk_nmi_en,
  input  wire logic                  i_parity_err,
  input  wire logic                  i_gate_a20,
  input  wire xbus_pkg::pin_in_s     i_pins,
  output xbus_pkg::pin_in_s          o_pins,
  output xbus_pkg::pin_in_s          o_pins_oe,
  output logic                       o_bus_clk,
  output logic                       o_addr_latch_n,
  output logic                       o_int_ack_n,
  output logic                       o_low_meg_select_n,
  output logic                       o_bios_rom_select_n,
  output logic                       o_bios_rom_out_en_n,
  output logic                       o_buf_dir_low_byte,
  output logic                       o_buf_dir_high_byte,
  output logic                       o_data_buf_enable_n,
  output logic                       o_wide_access,
  output logic                       o_nmi,
  output logic                       o_chk_error
);
  import xbus_pkg::*;

  // returns divisor code for the two-bit clock selection
  function automatic logic [`XB_DIV_W-1:0] div_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_of = `XB_DIV_CODE0;
      2'h1: div_of = `XB_DIV_CODE1;
      2'h2: div_of = `XB_DIV_CODE2;
      default: div_of = `XB_DIV_CODE3;
    endcase
  endfunction : div_of

  // true when the address falls in the bios rom window
  function automatic logic is_rom(input logic [`XB_ADDR_TOP:0] a);
    is_rom = ((a & `XB_ROM_MASK) == `XB_ROM_BASE);
  endfunction : is_rom

  logic [`XB_DIV_W-1:0]  div_cnt_r;
  logic                  bclk_r;
  logic                  bclk_rise;
  logic                  bclk_fall;
  xbus_state_e           state_r;
  cpu_req_s              req_r;
  logic [`XB_WAIT_W-1:0] wait_r;
  logic                  wide_r;
  logic                  first_cmd_r;
  logic                  rom_oe_r;
  logic                  refresh_r;
  logic                  ext_cycle;
  logic                  cmd_active;
  logic                  is_mem;
  logic                  is_io;

  // bus clock divider; each half period lasts div_of counts of i_clk
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_cnt_r <= `XB_CNT_ZERO;
      bclk_r    <= 1'b0;
    end else if (div_cnt_r >= div_of(i_clk_div_sel) - `XB_CNT_ONE) begin
      div_cnt_r <= `XB_CNT_ZERO;
      bclk_r    <= ~bclk_r;
    end else begin
      div_cnt_r <= div_cnt_r + `XB_CNT_ONE;
    end
  end
  assign bclk_rise = (div_cnt_r >= div_of(i_clk_div_sel) - `XB_CNT_ONE)
                     && !bclk_r;
  assign bclk_fall = (div_cnt_r >= div_of(i_clk_div_sel) - `XB_CNT_ONE)
                     && bclk_r;
  assign o_bus_clk = bclk_r;

  assign ext_cycle  = i_dma_cycle | i_master_cycle;
  assign is_mem     = (req_r.kind == cyc_mem_rd) || (req_r.kind == cyc_mem_wr);
  assign is_io      = (req_r.kind == cyc_io_rd) || (req_r.kind == cyc_io_wr);
  assign cmd_active = (state_r == st_cmd);

  // cpu cycle sequencer, advanced only on bus clock rising edges
  // while idle a cpu request is refused during an external cycle or a refresh request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r     <= st_idle;
      req_r       <= '0;
      wait_r      <= `XB_WAIT_ZERO;
      wide_r      <= 1'b0;
      first_cmd_r <= 1'b0;
    end else if (bclk_rise) begin
      unique case (state_r)
        st_idle: begin
          if (i_cpu_req && !ext_cycle && !i_refresh_req) begin
            req_r   <= i_cpu;
            state_r <= st_addr;
          end
        end
        st_addr: begin
          // width picked from slave indications at command start
          wide_r      <= (is_io && !i_io_wide_slave_n) ||
                         (is_mem && !i_pins.m16_n);
          wait_r      <= ((is_io && !i_io_wide_slave_n) ||
                          (is_mem && !i_pins.m16_n)) ?
                         `XB_WAIT_16BIT : `XB_WAIT_8BIT;
          first_cmd_r <= 1'b1;
          state_r     <= st_cmd;
        end
        st_cmd: begin
          first_cmd_r <= 1'b0;
          if (!i_no_wait_req_n) begin
            state_r <= st_end;
          end else if (!i_channel_ready_in) begin
            state_r <= st_cmd;
          end else if (wait_r == `XB_WAIT_ZERO) begin
            state_r <= st_end;
          end else begin
            wait_r <= wait_r - `XB_WAIT_ONE;
          end
        end
        st_end: state_r <= st_idle;
      endcase
    end
  end
  assign o_cpu_done    = (state_r == st_end) && bclk_rise;
  assign o_wide_access = wide_r;

  // rom output enable: set half a state into the first t2, dropped half a state after the last t2
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rom_oe_r <= 1'b0;
    end else if (bclk_fall && cmd_active && first_cmd_r) begin
      rom_oe_r <= is_rom(req_r.addr) && (req_r.kind == cyc_mem_rd);
    end else if (bclk_fall && state_r == st_end) begin
      rom_oe_r <= 1'b0;
    end
  end

  // refresh indication asserted for our own refresh requests
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      refresh_r <= 1'b0;
    end else begin
      refresh_r <= i_refresh_req && !ext_cycle && (state_r == st_idle);
    end
  end

  // pin outputs; data levels from flops or the sequencer state
  always_comb begin
    o_pins           = '1;
    o_pins.addr0     = req_r.addr[0];
    o_pins.gated_addr_bit20      = i_gate_a20 & req_r.addr[`XB_MEG_BIT];
    o_pins.bhe_n     = !(req_r.bhe && (state_r != st_idle));
    o_pins.m16_n     = 1'b0; // local memory is 16 bits wide
    o_pins.refresh_n = !refresh_r;
    o_pins.cmd_n[3]  = !(cmd_active && req_r.kind == cyc_io_rd);
    o_pins.cmd_n[2]  = !(cmd_active && req_r.kind == cyc_io_wr);
    o_pins.cmd_n[1]  = !(cmd_active && req_r.kind == cyc_mem_rd);
    o_pins.cmd_n[0]  = !(cmd_active && req_r.kind == cyc_mem_wr);
  end

  // enables: strobes and refresh released for every external cycle while its dma or master flag is high
  always_comb begin
    o_pins_oe           = '0;
    o_pins_oe.addr0     = !i_master_cycle &&
                          !(i_dma_cycle && i_dma_8bit);
    o_pins_oe.gated_addr_bit20      = !i_master_cycle;
    o_pins_oe.bhe_n     = !i_master_cycle;
    o_pins_oe.m16_n     = i_master_cycle && i_master_local_mem;
    o_pins_oe.refresh_n = !ext_cycle;
    o_pins_oe.cmd_n     = ext_cycle ? 4'h0 : 4'hf;
  end

  // cpu-side strobes and buffer steering
  assign o_addr_latch_n      = ext_cycle ? 1'b1 :
                               !(state_r == st_addr);
  assign o_int_ack_n         = !(cmd_active && req_r.kind == cyc_int_ack_n);
  assign o_low_meg_select_n  = !(is_mem && state_r != st_idle &&
                               !(|req_r.addr[`XB_ADDR_TOP:`XB_MEG_BIT]));
  assign o_bios_rom_out_en_n = !rom_oe_r;
  assign o_bios_rom_select_n = ext_cycle ?
                               !(i_master_mem_rd && !i_pins.cmd_n[1]) :
                               !(rom_oe_r);
  // write or io write: toward bus; reads: back to peripheral bus
  assign o_buf_dir_low_byte  = (req_r.kind == cyc_mem_wr) ||
                               (req_r.kind == cyc_io_wr);
  assign o_buf_dir_high_byte = o_buf_dir_low_byte;
  assign o_data_buf_enable_n = !(!ext_cycle && state_r != st_idle);

  // channel check: error flag always, nmi only when enabled
  assign o_chk_error = !i_channel_check_n;
  assign o_nmi       = i_parity_err ||
                       (!i_channel_check_n && i_chk_nmi_en);
endmodule : expansion_bus_interface

// *** test/ebi_sva.sv ***
// checker: port-level properties of the expansion bus interface
// assumes a bind into expansion_bus_interface, one clock domain
`timescale 1ns/100ps
module ebi_sva (
  input wire logic              i_clk,
  input wire logic              i_srst,
  input wire logic              i_dma_cycle,
  input wire logic              i_dma_8bit,
  input wire logic              i_master_cycle,
  input wire logic              i_master_local_mem,
  input wire logic              i_channel_ready_in,
  input wire logic              i_no_wait_req_n,
  input wire logic              i_channel_check_n,
  input wire logic              i_chk_nmi_en,
  input wire logic              i_parity_err,
  input wire xbus_pkg::pin_in_s o_pins,
  input wire xbus_pkg::pin_in_s o_pins_oe,
  input wire logic              o_addr_latch_n,
  input wire logic              o_int_ack_n,
  input wire logic              o_nmi,
  input wire logic              o_chk_error
);
  import xbus_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // a cpu command strobe is out on the bus
  wire cmd_on = o_pins_oe.cmd_n != 4'h0 && o_pins.cmd_n != 4'hf;
  wire ext = i_dma_cycle || i_master_cycle;
  sequence s_stall; cmd_on && !i_channel_ready_in; endsequence
  sequence s_fast; cmd_on && !i_no_wait_req_n; endsequence
  // a stalled strobe must stay; zero wait ends it within 12 master clocks
  property p_wait; s_stall |=> cmd_on; endproperty
  a_wait: assert property (p_wait)
    else $error("strobe dropped while not ready");
  property p_zero; s_fast |-> ##[1:12] !cmd_on; endproperty
  a_zero: assert property (p_zero)
    else $error("zero wait cycle not ended");
  // far side owns these pins in its own cycles (addr0 not in 16-bit dma, gate and bhe only in master), except m16_n in master local memory cycles
  property p_addr0; i_master_cycle || i_dma_cycle && i_dma_8bit
    |-> !o_pins_oe.addr0; endproperty
  a_addr0: assert property (p_addr0)
    else $error("address bit 0 driven in foreign cycle");
  property p_float; ext
    |-> o_pins_oe.cmd_n == 4'h0 && !o_pins_oe.refresh_n; endproperty
  a_float: assert property (p_float)
    else $error("strobe or refresh driven in foreign cycle");
  property p_master; i_master_cycle
    |-> !o_pins_oe.gated_addr_bit20 && !o_pins_oe.bhe_n; endproperty
  a_master: assert property (p_master)
    else $error("gate or byte high driven in master cycle");
  property p_m16;
    o_pins_oe.m16_n == (i_master_cycle && i_master_local_mem);
  endproperty
  a_m16: assert property (p_m16)
    else $error("wide memory pin direction wrong");
  property p_ale; ext |-> o_addr_latch_n; endproperty
  a_ale: assert property (p_ale)
    else $error("address latch low in foreign cycle");
  property p_nmi;
    o_nmi == (!i_channel_check_n && i_chk_nmi_en || i_parity_err);
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi does not follow its sources");
  property p_chk; !i_channel_check_n |-> o_chk_error; endproperty
  a_chk: assert property (p_chk)
    else $error("channel check not flagged");
  property p_reset; $fell(i_srst)
    |-> o_addr_latch_n && o_int_ack_n && o_pins.cmd_n == 4'hf;
  endproperty
  a_reset: assert property (p_reset)
    else $error("strobe active after reset");
endmodule : ebi_sva
bind expansion_bus_interface ebi_sva chk_u (.*);

// *** test/ebi_slave_model.sv ***
// far-side model: expansion slave that answers cpu command strobes
// assumes the bench picks the answer mode before each cycle
`timescale 1ns/100ps
module ebi_slave_model (
  input  wire logic              i_clk,
  input  wire logic [1:0]        i_mode,  // 0 prompt, 1 slow, 2 no wait
  input  wire logic              i_wide,
  input  wire xbus_pkg::pin_in_s i_pins_out,
  input  wire xbus_pkg::pin_in_s i_pins_oe,
  input  wire xbus_pkg::pin_in_s i_ext,
  output logic                   o_ready,
  output logic                   o_no_wait_n,
  output logic                   o_io_wide_n,
  output xbus_pkg::pin_in_s      o_pins
);
  import xbus_pkg::*;
  logic [3:0] cnt_r;
  wire seen = i_pins_oe.cmd_n != 4'h0 && i_pins_out.cmd_n != 4'hf;
  // each wire shows whoever enables it, else the far side's own value
  assign o_pins = pin_in_s'((i_pins_out & i_pins_oe) | (i_ext & ~i_pins_oe));
  assign o_io_wide_n = !i_wide;
  // slow slave pulls ready low at once on a decoded strobe, 12 clocks
  assign o_ready = !(i_mode == 2'h1 && seen && cnt_r < 4'hc);
  assign o_no_wait_n = !(i_mode == 2'h2 && seen);
  // strobe age, saturating so a stuck strobe never re-stalls
  always_ff @(posedge i_clk) begin
    cnt_r <= seen ? cnt_r + 4'(cnt_r != 4'hf) : 4'h0;
  end
endmodule : ebi_slave_model

// *** test/tb.sv ***
// self-checking bench for the expansion bus interface
// assumes design, checker and slave model are compiled before it
`timescale 1ns/100ps
module tb;
  import xbus_pkg::*;
  logic i_clk, i_srst, i_cpu_req, i_dma_cycle, i_dma_8bit, i_master_cycle;
  logic i_master_local_mem, i_master_mem_rd, i_refresh_req, i_gate_a20;
  logic i_channel_ready_in, i_no_wait_req_n, i_io_wide_slave_n, wide;
  logic i_channel_check_n, i_chk_nmi_en, i_parity_err, o_cpu_done, o_bus_clk;
  logic o_addr_latch_n, o_int_ack_n, o_low_meg_select_n, o_bios_rom_select_n;
  logic o_bios_rom_out_en_n, o_buf_dir_low_byte, o_buf_dir_high_byte;
  logic o_data_buf_enable_n, o_wide_access, o_nmi, o_chk_error;
  logic [1:0] i_clk_div_sel, mode;
  logic [23:0] a;
  logic b, rs;
  cpu_req_s i_cpu;
  pin_in_s i_pins, o_pins, o_pins_oe, ext;
  logic exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int t;
  expansion_bus_interface dut_u (.*);
  ebi_slave_model far_u (.i_clk(i_clk), .i_mode(mode), .i_wide(wide),
    .i_pins_out(o_pins), .i_pins_oe(o_pins_oe), .i_ext(ext),
    .o_ready(i_channel_ready_in), .o_no_wait_n(i_no_wait_req_n),
    .o_io_wide_n(i_io_wide_slave_n), .o_pins(i_pins));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t mismatch got %b want %b", $time, g, e);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic summarize;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // one cpu cycle: latch, strobe, then done; width noted for the monitor
  task automatic cpu_cycle(input cyc_kind_e k);
    i_cpu.kind = k;
    i_cpu.addr = a;
    i_cpu.bhe = a[1];
    if (k != cyc_int_ack_n)
      exp_q.push_back(k inside {cyc_io_rd, cyc_io_wr} ? wide : !ext.m16_n);
    i_cpu_req = 1'b1;
    for (t = 0; t < 99 && o_addr_latch_n !== 1'b0; t++) step(1);
    check(o_addr_latch_n, 1'b0);
    for (t = 0; t < 99 && o_pins.cmd_n === 4'hf && o_int_ack_n; t++) step(1);
    check(o_pins.cmd_n === (4'hf ^ (k == cyc_int_ack_n ? 4'h0 :
      4'h8 >> ((k + 2) % 4))), 1'b1);
    check(o_int_ack_n, k != cyc_int_ack_n);
    check(o_pins.bhe_n, !a[1]);
    check(o_pins.gated_addr_bit20, i_gate_a20 & a[20]);
    check(o_buf_dir_high_byte, k[0]);
    if (k != cyc_int_ack_n) begin
      check(o_data_buf_enable_n, 1'b0);
      check(o_buf_dir_low_byte, k[0]);
      check(o_low_meg_select_n, k[1] || a >= 24'h100000);
    end
    // rom enable and select must be low together at some point in a rom read cycle, never together in others
    rs = 1'b0;
    for (t = 0; t < 999 && o_cpu_done !== 1'b1; t++) begin
      rs |= !o_bios_rom_out_en_n && !o_bios_rom_select_n;
      step(1);
    end
    check(o_cpu_done, 1'b1);
    check(rs, k == cyc_mem_rd && a[23:17] == 7'h07);
    step(1);
    i_cpu_req = 1'b0;
    step(2);
  endtask : cpu_cycle
  // each done is judged against the oldest note left by the driver
  always @(posedge i_clk)
    if (o_cpu_done === 1'b1 && i_cpu.kind != cyc_int_ack_n && exp_q.size() > 0)
      check(o_wide_access, exp_q.pop_front());
  initial begin
    #300000;
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'h9ea6425c));
    {i_cpu_req, i_dma_cycle, i_dma_8bit, i_master_cycle} = '0;
    {i_master_local_mem, i_master_mem_rd, i_refresh_req, i_parity_err} = '0;
    {i_channel_check_n, i_chk_nmi_en, i_gate_a20, wide} = 4'h9;
    {i_clk_div_sel, mode, a} = '0;
    i_cpu = '0;
    ext = '1;
    i_srst = 1'b1;
    step(20);
    i_srst = 1'b0;
    step(2);
    for (int d = 0; d < 4; d++) begin
      i_clk_div_sel = 2'(d);
      // half period of the bus clock, counted in master clocks
      step(12);
      b = o_bus_clk;
      for (t = 0; t < 99 && o_bus_clk === b; t++) step(1);
      b = o_bus_clk;
      for (t = 0; t < 99 && o_bus_clk === b; t++) step(1);
      check(t == d + 2, 1'b1);
      for (int k = 0; k < 5; k++) begin
        {mode, wide, i_gate_a20} = {2'($urandom_range(2)), 2'($urandom)};
        ext = pin_in_s'($urandom);
        a = 24'($urandom) >> (d * 2);
        if (k == 0 && d[0]) a = 24'h0e0000 | {7'h0, a[16:0]};
        cpu_cycle(cyc_kind_e'(k));
      end
    end
    $display("test cpu cycles done");
    // foreign cycles: dma 16, dma 8, master, master into local memory
    for (int i = 0; i < 4; i++) begin
      {i_dma_cycle, i_dma_8bit, i_master_cycle} = {i < 2, i == 1, i > 1};
      {i_master_local_mem, i_master_mem_rd} = {i == 3, 1'($urandom)};
      step(4);
      check(o_pins_oe.addr0, i == 0);
      check(o_pins_oe.gated_addr_bit20 && o_pins_oe.bhe_n, i < 2);
      check(o_pins_oe.m16_n, i == 3);
      check(o_bios_rom_select_n,
            !(i_master_mem_rd && !ext.cmd_n[1]));
      check(o_pins_oe.refresh_n || o_addr_latch_n !== 1'b1, 1'b0);
    end
    {i_dma_cycle, i_dma_8bit, i_master_cycle, i_master_local_mem} = '0;
    step(4);
    $display("test foreign cycles done");
    i_refresh_req = 1'b1;
    for (t = 0; t < 99 && !(o_pins_oe.refresh_n && !o_pins.refresh_n); t++)
      step(1);
    check(o_pins.refresh_n, 1'b0);
    i_refresh_req = 1'b0;
    step(40);
    $display("test refresh done");
    for (int i = 0; i < 8; i++) begin
      {i_channel_check_n, i_chk_nmi_en, i_parity_err} = 3'(i);
      step(1);
      check(o_nmi, !i_channel_check_n && i_chk_nmi_en || i_parity_err);
      check(o_chk_error, !i_channel_check_n);
    end
    i_srst = 1'b1;
    step(2);
    i_srst = 1'b0;
    step(1);
    check(o_addr_latch_n && o_int_ack_n, 1'b1);
    $display("test error and reset done");
    summarize();
  end
endmodule : tb
